// ### rtl/pcrb_params.svh
// Offsets, field positions, reset values and write masks of the
// regulator control register bank. Assumes an includer that needs them.
`ifndef PCRB_PARAMS_SVH
`define PCRB_PARAMS_SVH

// Register indices; byte address is four times the index
`define PCRB_IDX_REV 8'h00
`define PCRB_IDX_TRIM 8'h01
`define PCRB_IDX_CTL 8'h02
`define PCRB_IDX_MASKA 8'h21
`define PCRB_IDX_MASKB 8'h22
`define PCRB_IDX_MASK01 8'h23
`define PCRB_IDX_MASK23 8'h24
`define PCRB_IDX_LDSEL 8'h25
`define PCRB_IDX_LDHI 8'h26
`define PCRB_IDX_LDLO 8'h27
`define PCRB_IDX_PGSEL 8'h28
`define PCRB_IDX_PGCFG 8'h29
`define PCRB_IDX_PGFLT 8'h2A
`define PCRB_IDX_SYNC 8'h2B
`define PCRB_IDX_PINFN 8'h2C
`define PCRB_IDX_GPCFG 8'h2D
`define PCRB_IDX_GPIN 8'h2E
`define PCRB_IDX_GPOUT 8'h2F
`define PCRB_IDX_EVT 8'h30
`define PCRB_IDX_EVTMSK 8'h31

// Phase control fields
`define PCRB_CTL_EN 7
`define PCRB_CTL_GATE 6
`define PCRB_CTL_DIS 2
`define PCRB_CTL_RST 8'h04
`define PCRB_CTL_WMASK 8'hF4

// Writable bits of the plain read/write slots, slot 0 to 10
`define PCRB_WM_MASKA 8'h15
`define PCRB_WM_MASKB 8'h01
`define PCRB_WM_MASKPH 8'h55
`define PCRB_WM_LDSEL 8'h03
`define PCRB_WM_ALL 8'hFF
`define PCRB_WM_PGCFG 8'hF7
`define PCRB_WM_SYNC 8'hDF
`define PCRB_WM_GPCFG 8'h77
`define PCRB_WM_GPOUT 8'h07
`define PCRB_SLOTS 11
`define PCRB_NOSLOT 4'hF

// Event bits of the sticky status register
`define PCRB_EV_ON 0
`define PCRB_EV_OFF 1
`define PCRB_EV_LOAD 2
`define PCRB_EV_PIN 3

`endif

// ### rtl/pcrb_pkg.sv
// Types of the regulator control register bank.
// Assumes the params header is compiled alongside.
package pcrb_pkg;
	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pcrb_apb_in_t;
	// APB answer to the master
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} pcrb_apb_out_t;
	// Trim memory image presented at reset
	typedef struct packed {
		logic [1:0] partId;
		logic [7:0] trimCode;
		logic phase0Enable;
		logic phase0PinGating;
		logic [1:0] phase0GatePinChoice;
		logic [1:0] ctlLow;
	} pcrb_otp_t;
	// Bus sequencer states, one-hot
	typedef enum logic [2:0] {
		BUS_WAIT = 3'b001,
		BUS_IDLE = 3'b010,
		BUS_DONE = 3'b100
	} pcrb_bus_t;
	// Whole state of the bank
	typedef struct packed {
		pcrb_bus_t bus;
		logic [7:0] ctl;
		logic [1:0] partId;
		logic [7:0] trimCode;
		logic [10:0][7:0] rw;
		logic [3:0] evtStat;
		logic [3:0] evtMask;
		logic [2:0] pinsPrev;
		logic [9:0] loadPrev;
		logic run;
		logic disch;
		logic [2:0] gpioDrv;
		logic [2:0] gpioOe;
		logic irq;
		pcrb_apb_out_t apbOut;
	} pcrb_state_t;
endpackage

// ### rtl/pcrb_sync.sv
// Two-flop synchroniser, one per bit.
// Assumes inputs asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pcrb_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw and synchronised levels
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);
	genvar i;
	// First stage feeds only the second stage
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta; // First stage, may go metastable
			logic settled; // Second stage, the only reader of meta
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta <= 1'b0;
					settled <= 1'b0;
				end else begin
					meta <= async[i];
					settled <= meta;
				end
			end
			// Each bit owns its own flops; the vector is only wired together
			assign synced[i] = settled;
		end
	endgenerate
endmodule // pcrb_sync
`default_nettype wire

// ### rtl/pcrb_top.sv
// Control and status register bank of a multiphase regulator,
// reached over APB, with phase-zero enable and discharge logic.
// Assumes the trim image is stable while rst is high and after.
//
// Notes on behaviour
// - Enable bit 7 switches phase zero on
// - Gating bit 6 adds chosen pin condition
// - Pin choice 0..2 picks pin; 3 reserved
// - Discharge bit 2, resistor on when off
// - Revision bits 7:6 identity from trim memory
// - Revision bits 5:4 all-layer version index
// - Revision bits 3:0 metal spin count
// - Offset one returns trim image code
// - Programmable defaults come from trim memory
`timescale 1ns/1ps
`default_nettype none
`include "pcrb_params.svh"
module pcrb_top import pcrb_pkg::*; #(
	// Revision figures; values are arbitrary
	parameter logic [1:0] ALL_LAYER_REV = 2'h0,
	parameter logic [3:0] METAL_SPIN = 4'h0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire pcrb_apb_in_t apbIn,
	output pcrb_apb_out_t apbOut,
	// Trim memory image
	input wire pcrb_otp_t otpImage,
	// Pins from outside
	input wire logic [2:0] enPins,
	input wire logic [2:0] gpioPinIn,
	// Same-clock measurement inputs
	input wire logic [9:0] loadCurrent,
	input wire logic [3:0] pgFault,
	// Regulator controls
	output logic phase0Run,
	output logic phase0Discharge,
	// General pins, drive and enable
	output logic [2:0] gpioPinOut,
	output logic [2:0] gpioPinOe,
	// Interrupt level
	output logic irq
);
	// Reset image; trim fields follow from memory one cycle later
	localparam pcrb_state_t ST_RST = '{
		bus: BUS_WAIT,
		ctl: `PCRB_CTL_RST,
		default: '0
	};

	pcrb_state_t st_r; // Registered state
	pcrb_state_t st_nxt; // Next state
	logic [5:0] pinsSync; // Enable pins and general pins, synchronised
	logic [2:0] enSync; // Enable pins
	logic [2:0] gpSync; // General pins
	logic [7:0] idx; // Register index of the request
	logic inRange; // Aligned and inside the window
	logic [3:0] slot; // Plain read/write slot or none
	logic known; // Index decodes to a register
	logic [7:0] rdData; // Read value of the addressed register
	logic selPin; // Chosen gating pin level
	logic runNow; // Next phase state
	logic loaded; // Trim image has been taken
	logic doWrite; // Write completes at this edge
	logic [3:0] clrBits; // Status bits cleared by software
	logic [3:0] setBits; // Status bits raised by events

	// Pins cross into clk before anything looks at them
	pcrb_sync #(
		.WIDTH(6)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async({gpioPinIn, enPins}),
		.synced(pinsSync)
	);
	assign enSync = pinsSync[2:0];
	assign gpSync = pinsSync[5:3];

	// Map an index onto a plain read/write slot
	function automatic logic [3:0] slotOf(input logic [7:0] i);
		case (i)
			`PCRB_IDX_MASKA: slotOf = 4'h0;
			`PCRB_IDX_MASKB: slotOf = 4'h1;
			`PCRB_IDX_MASK01: slotOf = 4'h2;
			`PCRB_IDX_MASK23: slotOf = 4'h3;
			`PCRB_IDX_LDSEL: slotOf = 4'h4;
			`PCRB_IDX_PGSEL: slotOf = 4'h5;
			`PCRB_IDX_PGCFG: slotOf = 4'h6;
			`PCRB_IDX_SYNC: slotOf = 4'h7;
			`PCRB_IDX_PINFN: slotOf = 4'h8;
			`PCRB_IDX_GPCFG: slotOf = 4'h9;
			`PCRB_IDX_GPOUT: slotOf = 4'hA;
			default: slotOf = `PCRB_NOSLOT;
		endcase
	endfunction

	// Writable bits per slot; reserved bits hold their reset zero
	function automatic logic [7:0] wmaskOf(input logic [3:0] s);
		case (s)
			4'h0: wmaskOf = `PCRB_WM_MASKA;
			4'h1: wmaskOf = `PCRB_WM_MASKB;
			4'h2: wmaskOf = `PCRB_WM_MASKPH;
			4'h3: wmaskOf = `PCRB_WM_MASKPH;
			4'h4: wmaskOf = `PCRB_WM_LDSEL;
			4'h6: wmaskOf = `PCRB_WM_PGCFG;
			4'h7: wmaskOf = `PCRB_WM_SYNC;
			4'h9: wmaskOf = `PCRB_WM_GPCFG;
			4'hA: wmaskOf = `PCRB_WM_GPOUT;
			default: wmaskOf = `PCRB_WM_ALL;
		endcase
	endfunction

	// Address decode; unaligned or far addresses are errors
	assign idx = apbIn.paddr[9:2];
	assign inRange = (apbIn.paddr[11:10] == 2'h0) && (apbIn.paddr[1:0] == 2'h0);
	assign slot = slotOf(idx);

	// Which indices answer at all
	always_comb begin
		case (idx)
			`PCRB_IDX_REV, `PCRB_IDX_TRIM, `PCRB_IDX_CTL,
			`PCRB_IDX_LDHI, `PCRB_IDX_LDLO, `PCRB_IDX_PGFLT,
			`PCRB_IDX_GPIN, `PCRB_IDX_EVT, `PCRB_IDX_EVTMSK: known = inRange;
			default: known = inRange && (slot != `PCRB_NOSLOT);
		endcase
	end

	// Read mux; live inputs are sampled in the setup cycle
	always_comb begin
		case (idx)
			`PCRB_IDX_REV: rdData = {st_r.partId, ALL_LAYER_REV, METAL_SPIN};
			`PCRB_IDX_TRIM: rdData = st_r.trimCode;
			`PCRB_IDX_CTL: rdData = st_r.ctl;
			`PCRB_IDX_LDHI: rdData = {6'h00, loadCurrent[9:8]};
			`PCRB_IDX_LDLO: rdData = loadCurrent[7:0];
			`PCRB_IDX_PGFLT: rdData = {4'h0, pgFault};
			`PCRB_IDX_GPIN: rdData = {5'h00, gpSync};
			`PCRB_IDX_EVT: rdData = {4'h0, st_r.evtStat};
			`PCRB_IDX_EVTMSK: rdData = {4'h0, st_r.evtMask};
			default: rdData = (slot == `PCRB_NOSLOT) ? 8'h00 : st_r.rw[slot];
		endcase
	end

	// Gating pin choice; the reserved code gates the phase off
	always_comb begin
		case (st_r.ctl[5:4])
			2'h0: selPin = enSync[0];
			2'h1: selPin = enSync[1];
			2'h2: selPin = enSync[2];
			default: selPin = 1'b0;
		endcase
	end

	// Phase runs on the bit alone, or on bit and pin when gated
	assign runNow = st_r.ctl[`PCRB_CTL_EN] && (!st_r.ctl[`PCRB_CTL_GATE] || selPin);

	assign loaded = (st_r.bus != BUS_WAIT);
	// A write lands only at the edge where pready is sampled
	assign doWrite = (st_r.bus == BUS_DONE) && apbIn.psel && apbIn.penable && apbIn.pwrite && known;
	assign clrBits = (doWrite && idx == `PCRB_IDX_EVT) ? apbIn.pwdata[3:0] : 4'h0;

	// Events; the load cycle has no history to compare with
	// Pin history starts at zero, so a pin that is high may log one event after reset
	always_comb begin
		setBits = 4'h0;
		setBits[`PCRB_EV_ON] = runNow && !st_r.run;
		setBits[`PCRB_EV_OFF] = !runNow && st_r.run;
		setBits[`PCRB_EV_LOAD] = loaded && (loadCurrent != st_r.loadPrev);
		setBits[`PCRB_EV_PIN] = loaded && (gpSync != st_r.pinsPrev);
	end

	// Next state
	always_comb begin
		st_nxt = st_r;
		case (st_r.bus)
			BUS_WAIT: begin
				// Take the programmable defaults from trim memory
				st_nxt.partId = otpImage.partId;
				st_nxt.trimCode = otpImage.trimCode;
				st_nxt.ctl[`PCRB_CTL_EN] = otpImage.phase0Enable;
				st_nxt.ctl[`PCRB_CTL_GATE] = otpImage.phase0PinGating;
				st_nxt.ctl[5:4] = otpImage.phase0GatePinChoice;
				st_nxt.ctl[1:0] = otpImage.ctlLow;
				st_nxt.bus = BUS_IDLE;
			end
			BUS_IDLE: begin
				// Setup cycle: answer in the following access cycle
				// An access whose setup fell in the load cycle is answered one cycle late
				if (apbIn.psel) begin
					st_nxt.apbOut.pready = 1'b1;
					st_nxt.apbOut.pslverr = !known;
					st_nxt.apbOut.prdata = (known && !apbIn.pwrite) ? {24'h000000, rdData} : 32'h00000000;
					st_nxt.bus = BUS_DONE;
				end
			end
			BUS_DONE: begin
				// Access cycle ends here; drop the answer
				st_nxt.apbOut = '0;
				st_nxt.bus = BUS_IDLE;
				if (doWrite) begin
					// Read-only indices fall through untouched
					if (idx == `PCRB_IDX_CTL) begin
						st_nxt.ctl = (st_r.ctl & ~`PCRB_CTL_WMASK) | (apbIn.pwdata[7:0] & `PCRB_CTL_WMASK);
					end else if (idx == `PCRB_IDX_EVTMSK) begin
						st_nxt.evtMask = apbIn.pwdata[3:0];
					end else if (slot != `PCRB_NOSLOT) begin
						st_nxt.rw[slot] = (st_r.rw[slot] & ~wmaskOf(slot)) | (apbIn.pwdata[7:0] & wmaskOf(slot));
					end
				end
			end
			default: begin
				// Unreachable code; recover to the loading state
				st_nxt.bus = BUS_WAIT;
			end
		endcase
		// A new event outweighs a clear in the same cycle
		st_nxt.evtStat = (st_r.evtStat & ~clrBits) | setBits;
		st_nxt.pinsPrev = gpSync;
		st_nxt.loadPrev = loadCurrent;
		st_nxt.run = runNow;
		st_nxt.disch = st_r.ctl[`PCRB_CTL_DIS] && !runNow;
		// Open-drain pins only ever pull low
		st_nxt.gpioDrv = st_nxt.rw[10][2:0] & ~st_nxt.rw[9][6:4];
		st_nxt.gpioOe = st_nxt.rw[9][2:0] & (~st_nxt.rw[9][6:4] | ~st_nxt.rw[10][2:0]);
		st_nxt.irq = |(st_nxt.evtStat & st_nxt.evtMask);
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign apbOut = st_r.apbOut;
	assign phase0Run = st_r.run;
	assign phase0Discharge = st_r.disch;
	assign gpioPinOut = st_r.gpioDrv;
	assign gpioPinOe = st_r.gpioOe;
	assign irq = st_r.irq;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_RUN_OFF: assert property (!st_r.ctl[7] |=> !phase0Run)
		else $error("phase ran with enable clear");
	AST_UNGATED: assert property (st_r.ctl[7] && !st_r.ctl[6] |=> phase0Run)
		else $error("ungated phase not running");
	AST_GATED: assert property (st_r.ctl[7] && st_r.ctl[6] |=> phase0Run == $past(selPin))
		else $error("gated phase ignores chosen pin");
	AST_RSVD_SEL: assert property (st_r.ctl[6] && st_r.ctl[5:4] == 2'h3 |=> !phase0Run)
		else $error("reserved pin choice ran phase");
	AST_DISCH: assert property (phase0Discharge |-> !phase0Run && $past(st_r.ctl[2]))
		else $error("discharge while running or disabled");
	AST_REV: assert property (st_r.bus == BUS_IDLE && apbIn.psel && !apbIn.penable && !apbIn.pwrite
		&& inRange && idx == 8'h00 |=> apbOut.pready
		&& apbOut.prdata[7:0] == {st_r.partId, ALL_LAYER_REV, METAL_SPIN})
		else $error("revision read wrong");
	AST_TRIM: assert property (st_r.bus == BUS_IDLE && apbIn.psel && !apbIn.penable && !apbIn.pwrite
		&& inRange && idx == 8'h01 |=> apbOut.prdata[7:0] == st_r.trimCode)
		else $error("trim code read wrong");
	AST_LOAD: assert property (st_r.bus == BUS_WAIT |=> st_r.partId == $past(otpImage.partId)
		&& st_r.ctl[7] == $past(otpImage.phase0Enable) && st_r.ctl[2])
		else $error("trim defaults not loaded");
	AST_RO: assert property (doWrite && idx == 8'h00 |=> $stable(st_r.partId) && $stable(st_r.trimCode))
		else $error("read-only register changed");

	// Software owns the enable bit once the trim image is in
	AST_EN_WRITE: assert property (doWrite && idx == `PCRB_IDX_CTL
		|=> st_r.ctl[`PCRB_CTL_EN] == $past(apbIn.pwdata[`PCRB_CTL_EN]))
		else $error("enable bit not written");

	// Each pin code follows its own synchronised pin, never a neighbour
	AST_PIN_ONE: assert property (st_r.ctl[7] && st_r.ctl[6] && st_r.ctl[5:4] == 2'h0
		|=> phase0Run == $past(enSync[0]))
		else $error("pin one choice ignored");
	AST_PIN_TWO: assert property (st_r.ctl[7] && st_r.ctl[6] && st_r.ctl[5:4] == 2'h1
		|=> phase0Run == $past(enSync[1]))
		else $error("pin two choice ignored");
	AST_PIN_THREE: assert property (st_r.ctl[7] && st_r.ctl[6] && st_r.ctl[5:4] == 2'h2
		|=> phase0Run == $past(enSync[2]))
		else $error("pin three choice ignored");

	// A disabled phase with the discharge bit set pulls its output down
	AST_DISCH_SET: assert property (st_r.ctl[`PCRB_CTL_DIS] && !st_r.ctl[`PCRB_CTL_EN] |=> phase0Discharge)
		else $error("discharge missing while disabled");

	// With the bit clear the resistor is never connected
	AST_DISCH_CLR: assert property (!st_r.ctl[`PCRB_CTL_DIS] |=> !phase0Discharge)
		else $error("discharge with bit clear");

	// The discharge bit comes out of reset set
	AST_DISCH_RST: assert property (st_r.bus == BUS_WAIT |-> st_r.ctl[`PCRB_CTL_DIS])
		else $error("discharge bit not set at reset");

	// Identity and trim code never move once loaded
	AST_ID_HOLD: assert property (loaded |=> $stable(st_r.partId) && $stable(st_r.trimCode))
		else $error("identity changed after load");

	// Trim code comes from the memory image, not from logic
	AST_TRIM_LOAD: assert property (st_r.bus == BUS_WAIT |=> st_r.trimCode == $past(otpImage.trimCode))
		else $error("trim code not loaded");

	// Gating, pin choice and the low control bits load from the image too
	AST_GATE_LOAD: assert property (st_r.bus == BUS_WAIT |=> st_r.ctl[6] == $past(otpImage.phase0PinGating)
		&& st_r.ctl[5:4] == $past(otpImage.phase0GatePinChoice)
		&& st_r.ctl[1:0] == $past(otpImage.ctlLow))
		else $error("gating defaults not loaded");

	// Reserved control bit 3 keeps its reset zero
	AST_CTL_RSVD: assert property (!st_r.ctl[3])
		else $error("reserved control bit set");

	// Trim-loaded low control bits are out of the host's reach
	AST_CTL_LOW_RO: assert property (doWrite && idx == `PCRB_IDX_CTL |=> $stable(st_r.ctl[1:0]))
		else $error("low control bits written");

	// Reserved bits of plain registers never leave zero
	AST_RW_RSVD: assert property ((st_r.rw[0] & ~`PCRB_WM_MASKA) == 8'h00
		&& (st_r.rw[9] & ~`PCRB_WM_GPCFG) == 8'h00)
		else $error("reserved register bit set");

	// Interrupt is a pure level of the unmasked sticky bits
	AST_IRQ_LEVEL: assert property (irq == |(st_r.evtStat & st_r.evtMask))
		else $error("interrupt level wrong");

	// An event lands even when a clear hits the same bit
	AST_SET_WINS: assert property (setBits != 4'h0 |=> (st_r.evtStat & $past(setBits)) == $past(setBits))
		else $error("event lost");

	// Uncleared status bits stay set
	AST_STICKY: assert property ((st_r.evtStat & ~clrBits) != 4'h0
		|=> (st_r.evtStat & $past(st_r.evtStat & ~clrBits)) == $past(st_r.evtStat & ~clrBits))
		else $error("status bit dropped");
endmodule // pcrb_top
`default_nettype wire

// ### test/tb_pmic_control_register_bank.sv
// Self-checking bench of the regulator control register bank over APB.
// Assumes pcrb_pkg and the params header are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "pcrb_params.svh"
module tb_pmic_control_register_bank import pcrb_pkg::*; ();
	// Clock, reset and bus
	logic clk;
	logic rst;
	pcrb_apb_in_t apbIn;
	pcrb_apb_out_t apbOut;
	// Trim image; identity values are arbitrary
	pcrb_otp_t otpImage;
	// Pins and measurements
	logic [2:0] enPins;
	logic [2:0] gpioPinIn;
	logic [2:0] gpioPinOut;
	logic [2:0] gpioPinOe;
	logic [9:0] loadCurrent;
	logic [3:0] pgFault;
	logic phase0Run;
	logic phase0Discharge;
	logic irq;
	// Bookkeeping
	int n_mismatch;
	int n_compared;
	logic [7:0] rdVal;
	logic errVal;
	// Plain read/write slots and their writable bits
	localparam logic [7:0] RW_IDX [0:10] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2B, 8'h2C, 8'h2D, 8'h2F};
	localparam logic [7:0] RW_MSK [0:10] = '{8'h15, 8'h01, 8'h55, 8'h55, 8'h03, 8'hFF, 8'hF7, 8'hDF, 8'hFF, 8'h77, 8'h07};

	// Revision figures set away from the defaults so a stuck field shows
	pcrb_top #(.ALL_LAYER_REV(2'h3), .METAL_SPIN(4'hC)) i_dut (.clk(clk), .rst(rst), .apbIn(apbIn),
		.apbOut(apbOut), .otpImage(otpImage), .enPins(enPins), .gpioPinIn(gpioPinIn),
		.loadCurrent(loadCurrent), .pgFault(pgFault), .phase0Run(phase0Run),
		.phase0Discharge(phase0Discharge), .gpioPinOut(gpioPinOut), .gpioPinOe(gpioPinOe), .irq(irq));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare and count; four-state equality so unknowns fail
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; waits for pready without assuming a latency
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clk);
		apbIn <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00}, pwdata: {24'h0, wd}};
		@(posedge clk);
		apbIn.penable <= 1'b1;
		@(posedge clk);
		while (apbOut.pready !== 1'b1) begin
			@(posedge clk);
		end
		rdVal = apbOut.prdata[7:0];
		errVal = apbOut.pslverr;
		apbIn.psel <= 1'b0;
		apbIn.penable <= 1'b0;
	endtask

	// Read and compare data with no error
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk({23'h0, errVal, rdVal}, {24'h0, exp});
	endtask

	// Identity, trim code and trim-loaded control defaults
	task automatic t_ident();
		rdchk(`PCRB_IDX_REV, 8'hFC);
		rdchk(`PCRB_IDX_TRIM, 8'hA5);
		rdchk(`PCRB_IDX_CTL, 8'h87);
		chk(phase0Run, 1'b1);
	endtask

	// Writes to read-only places leave them alone
	task automatic t_readonly();
		apb(1'b1, `PCRB_IDX_REV, 8'h00);
		apb(1'b1, `PCRB_IDX_TRIM, 8'h00);
		rdchk(`PCRB_IDX_REV, 8'hFC);
		rdchk(`PCRB_IDX_TRIM, 8'hA5);
		apb(1'b1, `PCRB_IDX_CTL, 8'hFF);
		rdchk(`PCRB_IDX_CTL, 8'hF7);
	endtask

	// Enable, gating, every pin choice, and the discharge path
	task automatic t_phase();
		for (int code = 0; code < 4; code++) begin
			enPins <= (code == 3) ? 3'h7 : 3'(1 << code);
			apb(1'b1, `PCRB_IDX_CTL, 8'hC4 | 8'(code << 4));
			repeat (4) @(posedge clk);
			chk({phase0Run, phase0Discharge}, (code == 3) ? 2'b01 : 2'b10);
			enPins <= 3'h0;
			repeat (4) @(posedge clk);
			chk(phase0Run, 1'b0);
		end
		apb(1'b1, `PCRB_IDX_CTL, 8'h84);
		repeat (2) @(posedge clk);
		chk({phase0Run, phase0Discharge}, 2'b10);
		apb(1'b1, `PCRB_IDX_CTL, 8'h04);
		repeat (2) @(posedge clk);
		chk({phase0Run, phase0Discharge}, 2'b01);
		apb(1'b1, `PCRB_IDX_CTL, 8'h00);
		repeat (2) @(posedge clk);
		chk(phase0Discharge, 1'b0);
	endtask

	// Reset values, reserved bits, read-only inputs, general pins, unmapped place
	task automatic t_regs();
		for (int i = 0; i < 11; i++) begin
			rdchk(RW_IDX[i], 8'h00);
			apb(1'b1, RW_IDX[i], 8'hFF);
			rdchk(RW_IDX[i], RW_MSK[i]);
		end
		// All open-drain driving high means released pins
		chk({gpioPinOut, gpioPinOe}, 6'h00);
		apb(1'b1, `PCRB_IDX_GPCFG, 8'h07);
		repeat (2) @(posedge clk);
		chk({gpioPinOut, gpioPinOe}, 6'h3F);
		rdchk(`PCRB_IDX_GPIN, 8'h05);
		rdchk(`PCRB_IDX_PGFLT, 8'h0A);
		apb(1'b0, 8'h03, 8'h00);
		chk({errVal, rdVal}, 9'h100);
	endtask

	// Sticky event, mask, level interrupt and write-one clear
	task automatic t_irq();
		apb(1'b1, `PCRB_IDX_EVTMSK, 8'h00);
		apb(1'b1, `PCRB_IDX_EVT, 8'h0F);
		loadCurrent <= 10'h2C3;
		repeat (3) @(posedge clk);
		rdchk(`PCRB_IDX_EVT, 8'h04);
		chk(irq, 1'b0);
		rdchk(`PCRB_IDX_LDHI, 8'h02);
		rdchk(`PCRB_IDX_LDLO, 8'hC3);
		apb(1'b1, `PCRB_IDX_EVTMSK, 8'h04);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		apb(1'b1, `PCRB_IDX_EVT, 8'h04);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		// Phase turning on, all three general pins moving, then the phase turning off
		apb(1'b1, `PCRB_IDX_CTL, 8'h84);
		gpioPinIn <= 3'h2;
		repeat (4) @(posedge clk);
		rdchk(`PCRB_IDX_EVT, 8'h09);
		apb(1'b1, `PCRB_IDX_CTL, 8'h04);
		repeat (2) @(posedge clk);
		rdchk(`PCRB_IDX_EVT, 8'h0B);
		apb(1'b1, `PCRB_IDX_EVT, 8'h0B);
		rdchk(`PCRB_IDX_EVT, 8'h00);
	endtask

	// Verdict and end of run
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		n_mismatch = 0;
		n_compared = 0;
		rst = 1'b1;
		apbIn = '0;
		otpImage = '{partId: 2'h3, trimCode: 8'hA5, phase0Enable: 1'b1, phase0PinGating: 1'b0,
			phase0GatePinChoice: 2'h0, ctlLow: 2'h3};
		enPins = 3'h0;
		gpioPinIn = 3'h5;
		loadCurrent = 10'h000;
		pgFault = 4'hA;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_ident();
		t_readonly();
		t_phase();
		t_regs();
		t_irq();
		tally_and_finish();
	end
endmodule // tb_pmic_control_register_bank
`default_nettype wire
